// >>> design/timer_irq_unit.sv
// Interrupt request, priority and vector logic with two prescaled down-counters.
`timescale 1ns/1ps
module timer_irq_unit
  import timer_irq_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_srst,
  // Core register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Pins and comparator outputs.
  input wire pins_t i_pins,
  output logic o_timer_output_line,
  output logic o_line3_port_bit,
  // Core interrupt handshake and vector fetch.
  output logic o_int_req,
  input wire logic i_int_ack,
  output logic o_save_context,
  output logic o_pm_rd,
  output logic [3:0] o_pm_addr,
  input wire logic [7:0] i_pm_data,
  output branch_t o_branch
);

  // Pin synchroniser and filtered levels.
  logic [5:0] sync1_reg, sync2_reg, sync3_reg, lvl_reg, lvl_d_reg;
  logic [5:0] lvl_next, rise, fall;

  // Request block state.
  logic [7:0] irq_reg, irq_next, mask_reg, mask_next;
  logic [2:0] prio_reg, prio_next;
  logic [1:0] cfg_reg, cfg_next;
  logic [5:0] hw_set, active;
  logic [3:0] grant;
  logic take;

  // Counter block state.
  logic [7:0] tmode_reg, tmode_next, init0_reg, init0_next, init1_reg, init1_next;
  logic [7:0] pre0_cfg_reg, pre0_cfg_next, pre1_cfg_reg, pre1_cfg_next;
  logic [7:0] cnt0_reg, cnt1_reg;
  logic [5:0] pre0_reg, pre1_reg;
  logic [1:0] div4_reg, div4_next;
  logic tout0_reg, tout0_next, tout1_reg, tout1_next, tout_reg, tout_next;
  tstep_t step0, step1;
  logic tick4, tick1, trig1, load0, load1;
  ext_mode_t ext_mode;

  // Vector sequence state.
  vec_state_t state_reg, state_next;
  logic [2:0] id_reg, id_next;
  logic [7:0] hi_reg, hi_next;
  branch_t branch_reg, branch_next;
  logic [7:0] rdata_next;

  // Register write decode.
  logic wr_irq, wr_mask, wr_tmode;
  assign wr_irq = i_reg_wr && (i_reg_addr == ADDR_IRQ);
  assign wr_mask = i_reg_wr && (i_reg_addr == ADDR_MASK);
  assign wr_tmode = i_reg_wr && (i_reg_addr == ADDR_TMODE);

  // A pin level changes only once the second and third stages agree.
  always_comb begin
    for (int b = 0; b < NUM_REQ; b++) begin
      lvl_next[b] = (sync2_reg[b] == sync3_reg[b]) ? sync2_reg[b] : lvl_reg[b];
    end
    rise = lvl_reg & ~lvl_d_reg;
    fall = ~lvl_reg & lvl_d_reg;
  end

  // Synchroniser registers.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      lvl_reg <= '0;
      lvl_d_reg <= '0;
    end else begin
      sync1_reg <= i_pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lvl_reg <= lvl_next;
      lvl_d_reg <= lvl_reg;
    end
  end

  // Hardware request sources and the edge each one listens to.
  always_comb begin
    logic an;
    logic [1:0] es;
    logic r1, f1, r2, f2;
    an = cfg_reg[CFG_ANALOG];
    es = irq_reg[IRQ_EDGE_HI:IRQ_EDGE_LO];
    r1 = an ? rise[3] : rise[0];
    f1 = an ? fall[3] : fall[0];
    r2 = an ? rise[4] : rise[1];
    f2 = an ? fall[4] : fall[1];
    hw_set = '0;
    hw_set[REQ_LINE1] = (es[1] && r1) || ((es == 2'h3 || !es[1]) && f1);
    hw_set[REQ_LINE2] = ((es[0]) && r2) || ((es == 2'h3 || !es[0]) && f2);
    hw_set[REQ_LINE3] = an ? fall[5] : fall[2];
    hw_set[REQ_FIRST_CNT] = step0.eoc;
    hw_set[REQ_SECOND_CNT] = step1.eoc;
  end

  // The line-3 port bit follows the same source as its request.
  assign o_line3_port_bit = cfg_reg[CFG_ANALOG] ? lvl_reg[5] : lvl_reg[2];

  // Priority resolution and the request to the core.
  assign active = irq_reg[5:0] & mask_reg[5:0];
  assign grant = pick_req(active, prio_reg);
  assign o_int_req = (state_reg == ST_IDLE) && mask_reg[MASK_GLOBAL] && grant[3];
  assign take = o_int_req && i_int_ack;

  // Request, mask, priority and configuration registers.
  always_comb begin
    irq_next = wr_irq ? i_reg_wdata : irq_reg;
    if (take) begin
      irq_next[grant[2:0]] = 1'b0;
    end
    irq_next[5:0] = irq_next[5:0] | hw_set; // Hardware set beats any clear.
    mask_next = wr_mask ? i_reg_wdata : mask_reg;
    if (take) begin
      mask_next[MASK_GLOBAL] = 1'b0;
    end
    prio_next = (i_reg_wr && i_reg_addr == ADDR_PRIO) ? i_reg_wdata[2:0] : prio_reg;
    cfg_next = (i_reg_wr && i_reg_addr == ADDR_CFG) ? i_reg_wdata[1:0] : cfg_reg;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_reg <= IRQ_RST;
      mask_reg <= MASK_RST;
      prio_reg <= PRIO_RST;
      cfg_reg <= CFG_RST;
    end else begin
      irq_reg <= irq_next;
      mask_reg <= mask_next;
      prio_reg <= prio_next;
      cfg_reg <= cfg_next;
    end
  end

  // Counter sources, triggers and steps.
  assign ext_mode = ext_mode_t'(tmode_reg[TM_EXT_LO +: 2]);
  assign tick4 = (div4_reg == 2'h3);
  assign load0 = wr_tmode && i_reg_wdata[TM_LOAD0];
  always_comb begin
    logic ext;
    ext = !pre1_cfg_reg[PRE_INT_SEL] && !cfg_reg[CFG_CASCADE];
    // The first counter steps before the second, whose cascade tick reads its end of count.
    step0 = timer_step(cnt0_reg, init0_reg, pre0_reg, pre0_cfg_reg[7:PRE_DIV_LO], tick4,
                       tmode_reg[TM_RUN0], load0, pre0_cfg_reg[PRE_CONT]);
    if (cfg_reg[CFG_CASCADE]) begin
      tick1 = step0.eoc;
    end else if (!ext) begin
      tick1 = tick4;
    end else begin
      case (ext_mode)
        EXT_CLOCK: tick1 = rise[0];
        EXT_GATE: tick1 = tick4 && lvl_reg[0];
        default: tick1 = tick4;
        // Trigger modes count the divided clock once running.
      endcase
    end
    trig1 = ext && rise[0] && ((ext_mode == EXT_TRIG_RETRIG) ||
            (ext_mode == EXT_TRIG_ONCE && !tmode_reg[TM_RUN1]));
    load1 = (wr_tmode && i_reg_wdata[TM_LOAD1]) || trig1;
    step1 = timer_step(cnt1_reg, init1_reg, pre1_reg, pre1_cfg_reg[7:PRE_DIV_LO], tick1,
                       tmode_reg[TM_RUN1], load1, pre1_cfg_reg[PRE_CONT]);
  end

  // Counter control, configuration and output line.
  always_comb begin
    tmode_next = wr_tmode ? i_reg_wdata : tmode_reg;
    tmode_next[TM_LOAD0] = 1'b0;
    tmode_next[TM_LOAD1] = 1'b0;
    if (trig1) begin
      tmode_next[TM_RUN1] = 1'b1;
    end
    if (step0.eoc && !pre0_cfg_reg[PRE_CONT]) begin
      tmode_next[TM_RUN0] = 1'b0;
    end
    if (step1.eoc && !pre1_cfg_reg[PRE_CONT]) begin
      tmode_next[TM_RUN1] = 1'b0;
    end
    init0_next = (i_reg_wr && i_reg_addr == ADDR_CNT0) ? i_reg_wdata : init0_reg;
    init1_next = (i_reg_wr && i_reg_addr == ADDR_CNT1) ? i_reg_wdata : init1_reg;
    pre0_cfg_next = (i_reg_wr && i_reg_addr == ADDR_PRE0) ? i_reg_wdata : pre0_cfg_reg;
    pre1_cfg_next = (i_reg_wr && i_reg_addr == ADDR_PRE1) ? i_reg_wdata : pre1_cfg_reg;
    div4_next = div4_reg + 2'h1;
    tout0_next = tout0_reg ^ step0.eoc;
    tout1_next = tout1_reg ^ step1.eoc;
    case (out_sel_t'(tmode_reg[TM_OUT_LO +: 2]))
      OUT_FIRST: tout_next = tout0_reg;
      OUT_SECOND: tout_next = tout1_reg;
      OUT_CLOCK: tout_next = div4_reg[1];
      default: tout_next = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tmode_reg <= TMODE_RST;
      init0_reg <= INIT_RST;
      init1_reg <= INIT_RST;
      pre0_cfg_reg <= PRE_RST;
      pre1_cfg_reg <= PRE_RST;
      cnt0_reg <= INIT_RST;
      cnt1_reg <= INIT_RST;
      pre0_reg <= '0;
      pre1_reg <= '0;
      div4_reg <= '0;
      tout0_reg <= 1'b0;
      tout1_reg <= 1'b0;
      tout_reg <= 1'b0;
    end else begin
      tmode_reg <= tmode_next;
      init0_reg <= init0_next;
      init1_reg <= init1_next;
      pre0_cfg_reg <= pre0_cfg_next;
      pre1_cfg_reg <= pre1_cfg_next;
      cnt0_reg <= step0.cnt;
      cnt1_reg <= step1.cnt;
      pre0_reg <= step0.pre;
      pre1_reg <= step1.pre;
      div4_reg <= div4_next;
      tout0_reg <= tout0_next;
      tout1_reg <= tout1_next;
      tout_reg <= tout_next;
    end
  end

  assign o_timer_output_line = tout_reg;

  // Grant sequence: save context, fetch both vector bytes, then branch.
  always_comb begin
    state_next = state_reg;
    id_next = id_reg;
    hi_next = hi_reg;
    branch_next = '0;
    o_save_context = 1'b0;
    o_pm_rd = 1'b0;
    o_pm_addr = {id_reg, 1'b0};
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          id_next = grant[2:0];
          state_next = ST_HI;
        end
      end
      ST_HI: begin
        o_save_context = 1'b1;
        o_pm_rd = 1'b1;
        state_next = ST_LO;
      end
      ST_LO: begin
        hi_next = i_pm_data;
        o_pm_rd = 1'b1;
        o_pm_addr = {id_reg, 1'b1};
        state_next = ST_DONE;
      end
      ST_DONE: begin
        branch_next.valid = 1'b1;
        branch_next.id = id_reg;
        branch_next.addr = {hi_reg, i_pm_data};
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= ST_IDLE;
      id_reg <= '0;
      hi_reg <= '0;
      branch_reg <= '0;
    end else begin
      state_reg <= state_next;
      id_reg <= id_next;
      hi_reg <= hi_next;
      branch_reg <= branch_next;
    end
  end

  assign o_branch = branch_reg;

  // Register reads have no side effects; prescaler counts never show.
  always_comb begin
    case (i_reg_addr)
      ADDR_IRQ: rdata_next = irq_reg;
      ADDR_MASK: rdata_next = mask_reg;
      ADDR_PRIO: rdata_next = {5'h00, prio_reg};
      ADDR_TMODE: rdata_next = tmode_reg;
      ADDR_CNT0: rdata_next = cnt0_reg;
      ADDR_CNT1: rdata_next = cnt1_reg;
      ADDR_CFG: rdata_next = {6'h00, cfg_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

endmodule : timer_irq_unit

// >>> design/timer_irq_pkg.sv
// Constants, types and helper functions shared by the timer and interrupt unit.
//
// Function
// - Six requests, individual and global mask.
// - Request N vector at bytes 2N, 2N+1.
// - Sources: three port lines, two counters, software.
// - Counter end of count raises its request.
// - Software request set only by register write.
// - Request bits 7:6 choose input edges.
// - Comparator outputs drive line requests in analog.
// - Programmable priority encoder picks pending request.
// - Grant disables interrupts, saves context, branches.
// - Pending flags readable while masked.
// - Two 8-bit counters with 6-bit prescalers.
// - Prescale 1..64, count from 1..256.
// - Start, stop, resume, restart from initial.
// - Single-pass halts; continuous mode reloads.
// - Counter reads harmless; prescalers unreadable.
// - Second counter clock internal/4 or external.
// - External input: clock, triggers, or gate.
// - Timer output shows counter or clock.
// - Counters can cascade first into second.
// - Line three source follows analog/digital mode.
package timer_irq_pkg;

  // Register addresses on the core's register port.
  localparam logic [7:0] ADDR_IRQ = 8'hfa;
  localparam logic [7:0] ADDR_MASK = 8'he0;
  localparam logic [7:0] ADDR_PRIO = 8'he1;
  localparam logic [7:0] ADDR_TMODE = 8'he2;
  localparam logic [7:0] ADDR_CNT0 = 8'he3;
  localparam logic [7:0] ADDR_PRE0 = 8'he4;
  localparam logic [7:0] ADDR_CNT1 = 8'he5;
  localparam logic [7:0] ADDR_PRE1 = 8'he6;
  localparam logic [7:0] ADDR_CFG = 8'he7;

  // Values after reset.
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [7:0] TMODE_RST = 8'h00;
  localparam logic [7:0] INIT_RST = 8'h00;
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [1:0] CFG_RST = 2'h0;

  // Field positions.
  localparam int IRQ_EDGE_LO = 6;
  localparam int IRQ_EDGE_HI = 7;
  localparam int MASK_GLOBAL = 7;
  localparam int TM_LOAD0 = 0;
  localparam int TM_RUN0 = 1;
  localparam int TM_LOAD1 = 2;
  localparam int TM_RUN1 = 3;
  localparam int TM_EXT_LO = 4;
  localparam int TM_OUT_LO = 6;
  localparam int PRE_CONT = 0;
  localparam int PRE_INT_SEL = 1;
  localparam int PRE_DIV_LO = 2;
  localparam int CFG_ANALOG = 0;
  localparam int CFG_CASCADE = 1;

  // Request numbers, which are also vector slots.
  localparam int REQ_LINE2 = 0;
  localparam int REQ_LINE3 = 1;
  localparam int REQ_LINE1 = 2;
  localparam int REQ_SOFTWARE = 3;
  localparam int REQ_FIRST_CNT = 4;
  localparam int REQ_SECOND_CNT = 5;
  localparam int NUM_REQ = 6;

  // External timer input modes.
  typedef enum logic [1:0] {
    EXT_CLOCK = 2'h0,
    EXT_GATE = 2'h1,
    EXT_TRIG_ONCE = 2'h2,
    EXT_TRIG_RETRIG = 2'h3
  } ext_mode_t;

  // Timer output selection.
  typedef enum logic [1:0] {
    OUT_OFF = 2'h0,
    OUT_FIRST = 2'h1,
    OUT_SECOND = 2'h2,
    OUT_CLOCK = 2'h3
  } out_sel_t;

  // Vector fetch sequence.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HI = 4'b0010,
    ST_LO = 4'b0100,
    ST_DONE = 4'b1000
  } vec_state_t;

  // Sampled pins.
  typedef struct packed {
    logic stop_src;
    logic cmp2;
    logic cmp1;
    logic ref_line;
    logic line2;
    logic line1;
  } pins_t;

  // Branch handed to the core after a grant.
  typedef struct packed {
    logic valid;
    logic [2:0] id;
    logic [15:0] addr;
  } branch_t;

  // One step of a counter with its prescaler.
  typedef struct packed {
    logic [7:0] cnt;
    logic [5:0] pre;
    logic eoc;
  } tstep_t;

  // Advances a prescaler and counter; a loaded zero stands for 64 or 256.
  function automatic tstep_t timer_step(input logic [7:0] cnt, input logic [7:0] init,
                                        input logic [5:0] pre, input logic [5:0] div,
                                        input logic tick, input logic run, input logic load,
                                        input logic cont);
    tstep_t r;
    r.cnt = cnt;
    r.pre = pre;
    r.eoc = 1'b0;
    if (load) begin
      r.cnt = init;
      r.pre = div;
    end else if (run && tick) begin
      if (pre == 6'h01) begin
        r.pre = div;
        if (cnt == 8'h01) begin
          r.eoc = 1'b1;
          r.cnt = cont ? init : 8'h00;
        end else begin
          r.cnt = cnt - 8'h01;
        end
      end else begin
        r.pre = pre - 6'h01;
      end
    end
    return r;
  endfunction : timer_step

  // Picks the first active request walking upward from the top-priority slot.
  function automatic logic [3:0] pick_req(input logic [5:0] act, input logic [2:0] first);
    logic [3:0] r;
    logic [2:0] idx;
    r = 4'h0;
    idx = 3'h0;
    for (int k = NUM_REQ - 1; k >= 0; k--) begin
      idx = 3'((int'(first) + k) % NUM_REQ);
      if (act[idx]) begin
        r = {1'b1, idx};
      end
    end
    return r;
  endfunction : pick_req

endpackage : timer_irq_pkg

// >>> dv/irq_unit_monitor.sv
// Port checks of the timer and interrupt unit.
`timescale 1ns/1ps
module irq_unit_monitor
  import timer_irq_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_srst,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // Grant and vector fetch.
  input wire logic o_int_req,
  input wire logic i_int_ack,
  input wire logic o_save_context,
  input wire logic o_pm_rd,
  input wire logic [3:0] o_pm_addr,
  input wire logic [7:0] i_pm_data,
  input wire branch_t o_branch
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // Grant sequence, vector bytes and read port behaviour.
  a_grant_saves: assert property (
    o_int_req && i_int_ack |=> o_save_context && o_pm_rd)
    else $error("no context save after grant");
  a_save_cause: assert property (
    o_save_context |-> $past(o_int_req && i_int_ack))
    else $error("context save without grant");
  a_int_quiet: assert property (
    o_int_req && i_int_ack |=> !o_int_req [*3])
    else $error("request raised during fetch");
  a_hi_then_lo: assert property (
    o_int_req && i_int_ack |=> !o_pm_addr[0] ##1 o_pm_rd && o_pm_addr[0])
    else $error("vector byte order wrong");
  a_branch_time: assert property (
    o_int_req && i_int_ack |-> ##4 o_branch.valid)
    else $error("branch late or missing");
  a_branch_pulse: assert property (
    o_branch.valid |=> !o_branch.valid)
    else $error("branch longer than one cycle");
  a_branch_id: assert property (
    o_branch.valid |-> {o_branch.id, 1'b0} == $past(o_pm_addr, 3))
    else $error("branch id does not match slot");
  a_branch_addr: assert property (
    o_branch.valid |-> o_branch.addr == {$past(i_pm_data, 2), $past(i_pm_data)})
    else $error("branch address not from vector");
  a_rdata_hold: assert property (
    !$past(i_reg_rd) && !$past(i_srst) |-> $stable(o_reg_rdata))
    else $error("read data moved without read");
  a_hidden_zero: assert property (
    i_reg_rd && (i_reg_addr == ADDR_PRE0 || i_reg_addr == ADDR_PRE1) |=> o_reg_rdata == 8'h00)
    else $error("prescaler readable");
endmodule : irq_unit_monitor

bind timer_irq_unit irq_unit_monitor u_mon (
  .i_clk(i_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .o_int_req(o_int_req), .i_int_ack(i_int_ack),
  .o_save_context(o_save_context), .o_pm_rd(o_pm_rd), .o_pm_addr(o_pm_addr),
  .i_pm_data(i_pm_data), .o_branch(o_branch));

// >>> dv/cpu_core_model.sv
// Core side model: vector bytes from program memory and the grant pulse.
`timescale 1ns/1ps
module cpu_core_model (
  // Clock and bench control.
  input wire logic i_clk,
  input wire logic i_ack_en,
  // Unit side.
  input wire logic i_int_req,
  input wire logic i_pm_rd,
  input wire logic [3:0] i_pm_addr,
  output logic o_int_ack,
  output logic [7:0] o_pm_data
);
  logic rd_q = 1'b0;
  logic [3:0] addr_q = 4'h0;

  // Fetch is captured mid-cycle so the answer never races the unit's own edge.
  always @(negedge i_clk) begin
    rd_q = i_pm_rd;
    addr_q = i_pm_addr;
  end

  // Byte answers the cycle after a fetch; idle cycles show a changing pattern.
  always @(posedge i_clk) begin
    #1;
    o_int_ack = i_ack_en && i_int_req && !o_int_ack;
    o_pm_data = rd_q ? {addr_q, ~addr_q} : ~o_pm_data;
  end

  initial begin
    o_int_ack = 1'b0;
    o_pm_data = 8'h00;
  end
endmodule : cpu_core_model

// >>> dv/timer_interrupt_unit_test.sv
// Self-checking bench for the timer and interrupt unit.
`timescale 1ns/1ps
module timer_interrupt_unit_test
  import timer_irq_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  pins_t i_pins = '0;
  logic ack_en = 1'b0;
  logic [7:0] o_reg_rdata, i_pm_data;
  logic o_timer_output_line, o_line3_port_bit, o_int_req, i_int_ack, o_save_context, o_pm_rd;
  logic [3:0] o_pm_addr;
  branch_t o_branch;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 46;
  int irq_model = 0;
  int n, p, s, v;

  // Clock and the two sides of the unit.
  always #2 i_clk = ~i_clk;
  timer_irq_unit u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_pins(i_pins), .o_timer_output_line(o_timer_output_line),
    .o_line3_port_bit(o_line3_port_bit), .o_int_req(o_int_req), .i_int_ack(i_int_ack),
    .o_save_context(o_save_context), .o_pm_rd(o_pm_rd), .o_pm_addr(o_pm_addr),
    .i_pm_data(i_pm_data), .o_branch(o_branch));
  cpu_core_model u_core (.i_clk(i_clk), .i_ack_en(ack_en), .i_int_req(o_int_req),
    .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr), .o_int_ack(i_int_ack), .o_pm_data(i_pm_data));

  // Compares one result and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Register write, one strobe cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1 i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(posedge i_clk);
    #1 i_reg_wr = 1'b0;
  endtask : wr

  // Register read; data shows the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    #1 i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(posedge i_clk);
    #1 i_reg_rd = 1'b0;
    chk(o_reg_rdata, e);
  endtask : rd

  // Request flag write, mirrored in the model.
  task automatic wirq(input int d);
    wr(ADDR_IRQ, 8'(d));
    irq_model = d;
  endtask : wirq

  // Lets the core grant and checks the branch against the vector slot.
  task automatic grant(input int id);
    logic [3:0] h;
    int k;
    h = 4'(2 * id);
    k = 0;
    ack_en = 1'b1;
    while (o_branch.valid !== 1'b1 && k < 40) begin
      @(posedge i_clk);
      #1 k++;
    end
    ack_en = 1'b0;
    chk(o_branch.valid, 1'b1);
    chk(o_branch.id, 16'(id));
    chk(o_branch.addr, {h, ~h, h + 4'h1, ~(h + 4'h1)});
    irq_model &= ~(1 << id);
  endtask : grant

  // Whether an edge sets a flag: select bit, rising or not, both-edge mode.
  function automatic int hit(input int b, input int r, input int both);
    return r ? b : (b == 0 || both);
  endfunction : hit

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog against a hang.
  initial begin
    #40000;
    miscompares++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_srst = 1'b0;
    rd(ADDR_IRQ, IRQ_RST);
    rd(ADDR_MASK, MASK_RST);
    rd(ADDR_PRE0, 8'h00);
    wirq(8'h08);
    wr(ADDR_MASK, 8'hb7);
    chk(o_int_req, 1'b0);
    rd(ADDR_IRQ, 8'(irq_model));
    wr(ADDR_MASK, 8'h88);
    grant(REQ_SOFTWARE);
    rd(ADDR_MASK, 8'h08);
    for (p = 0; p < NUM_REQ; p++) begin
      wirq(8'h3f);
      wr(ADDR_PRIO, 8'(p));
      wr(ADDR_MASK, 8'hbf);
      grant(p);
      rd(ADDR_IRQ, 8'(irq_model));
    end
    // Each edge select code, rising then falling on both lines and line three.
    for (s = 0; s < 4; s++) begin
      for (v = 1; v >= 0; v--) begin
        wirq(s << 6);
        i_pins.line1 = v[0];
        i_pins.line2 = v[0];
        i_pins.ref_line = v[0];
        repeat (8) @(posedge i_clk);
        irq_model |= (hit(s / 2, v, s == 3) << 2) | hit(s % 2, v, s == 3) | ((v == 0) << 1);
        rd(ADDR_IRQ, 8'(irq_model));
      end
    end
    // Analog mode: comparator one feeds line one, recovery source feeds line three.
    wr(ADDR_CFG, 8'h01);
    i_pins.cmp1 = 1'b1;
    i_pins.cmp2 = 1'b1;
    i_pins.stop_src = 1'b1;
    repeat (8) @(posedge i_clk);
    #1 chk(o_line3_port_bit, 1'b1);
    wirq(0);
    i_pins.cmp1 = 1'b0;
    i_pins.cmp2 = 1'b0;
    i_pins.stop_src = 1'b0;
    repeat (8) @(posedge i_clk);
    #1 chk(o_line3_port_bit, 1'b0);
    irq_model = 7;
    rd(ADDR_IRQ, 8'(irq_model));
    // Single pass on each counter from a random count.
    for (n = 0; n < 2; n++) begin
      v = 1 + ($unsigned($random(seed)) % 8);
      wr(8'(ADDR_CNT0 + 2 * n), 8'(v));
      wr(8'(ADDR_PRE0 + 2 * n), 8'h06);
      wr(ADDR_TMODE, 8'(1 << (2 * n)));
      wr(ADDR_TMODE, 8'((2 << (2 * n)) | ((n + 1) << 6)));
      repeat (4 * v + 20) @(posedge i_clk);
      rd(8'(ADDR_CNT0 + 2 * n), 8'h00);
      irq_model |= 16 << n;
      rd(ADDR_IRQ, 8'(irq_model));
      chk(o_timer_output_line, 1'b1);
    end
    // Cascade: a continuous first counter clocks a single-pass second counter.
    wr(ADDR_CNT0, 8'h02);
    wr(ADDR_PRE0, 8'h05);
    wr(ADDR_CNT1, 8'h03);
    wr(ADDR_CFG, 8'h02);
    wr(ADDR_TMODE, 8'h05);
    wirq(0);
    wr(ADDR_TMODE, 8'h0a);
    repeat (40) @(posedge i_clk);
    rd(ADDR_CNT1, 8'h00);
    rd(ADDR_TMODE, 8'h02);
    irq_model = 8'h30;
    rd(ADDR_IRQ, 8'(irq_model));
    // External clock on line one for the second counter; divided clock on the output line.
    wr(ADDR_CFG, 8'h00);
    wr(ADDR_PRE1, 8'h04);
    wr(ADDR_CNT1, 8'h03);
    wr(ADDR_TMODE, 8'h04);
    wirq(0);
    wr(ADDR_TMODE, 8'hc8);
    repeat (6) begin
      i_pins.line1 = ~i_pins.line1;
      repeat (8) @(posedge i_clk);
      #1;
    end
    rd(ADDR_CNT1, 8'h00);
    irq_model = 8'h24;
    rd(ADDR_IRQ, 8'(irq_model));
    v = 0;
    repeat (4) begin
      @(posedge i_clk);
      #1 v += o_timer_output_line;
    end
    chk(16'(v), 16'h0002);
    end_of_test();
  end
endmodule : timer_interrupt_unit_test
